// file: design/gsw_switch.sv
/*
 * speed-loop gain-set switch with its Avalon-MM register slave,
 * the 0.1 ms time base, the 1 ms change window and the set decision.
 * assumes torque and speed commands come from logic on MCLK and the
 * gain select pin is asynchronous.
 */
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - mode 0 keeps gain set one
// - mode 1 keeps gain set two
// - mode 2 follows gain select input
// - mode 3 judges torque change, 0.05% units
// - torque change measured over 1 ms
// - mode 4 judges speed change, 10 r/min/s
// - mode 5 judges speed command in r/min
// - modes apply only when op select is 1
// - mode 1 with limit select 3/6 forces set one
// - delay only on set two to one
// - delay 0..10000 x 0.1 ms, modes 3-5
// - level 0..20000 threshold, speed mode, 3-5
// - hysteresis symmetric around level
// - magnitudes compared, sign ignored
// - lower position gain applied at once
// - higher position gain ramped over set time
module gsw_switch #(
	parameter int TICK_CYCLES = gsw_pkg::TICK_CYCLES_DEF
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire gsw_pkg::gsw_avs_req_type AVS_REQ,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic GAIN_SELECT_INPUT,
	input wire logic signed [gsw_pkg::CMD_W-1:0] TORQUE_CMD,
	input wire logic signed [gsw_pkg::CMD_W-1:0] SPEED_CMD,
	output logic GAIN_SET_TWO,
	output logic [gsw_pkg::GAIN_W-1:0] POSITION_LOOP_GAIN
);
	import gsw_pkg::*;

	typedef struct packed {
		logic waitreq;
		logic [31:0] rdata;
		logic [2:0] speed_loop_switch_mode;
		logic gain_input_op_select;
		logic speed_ctrl_mode;
		logic [3:0] torque_limit_select;
		logic [TIME_W-1:0] speed_switch_delay;
		logic [LVL_W-1:0] speed_switch_level;
		logic [LVL_W-1:0] speed_switch_hysteresis;
		logic [TIME_W-1:0] position_gain_ramp_time;
		logic [GAIN_W-1:0] position_loop_gain_first;
		logic [GAIN_W-1:0] position_loop_gain_second;
		logic [PRE_W-1:0] prescale;
		logic tick;
		logic [3:0] win_cnt;
		logic win_end;
		logic signed [CMD_W-1:0] torque_prev;
		logic signed [CMD_W-1:0] speed_prev;
		logic [MAG_W-1:0] torque_mag;
		logic [MAG_W-1:0] rate_mag;
		gsw_sel_type sel;
		logic [TIME_W-1:0] wait_cnt;
		logic set_two;
	} gsw_top_state_type;

	gsw_top_state_type s;
	gsw_top_state_type next_s;
	logic gain_select_input;
	logic [GAIN_W-1:0] pos_gain;

	// magnitude of a signed difference, sign dropped
	function automatic logic [CMD_W:0] magnitude(
		input logic signed [CMD_W:0] v
	);
		magnitude = v[CMD_W] ? (CMD_W+1)'(0) - v : v;
	endfunction

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0] be
	);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge[8*i +: 8] = wdata[8*i +: 8];
			end
		end
	endfunction

	gsw_sync u_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.pin(GAIN_SELECT_INPUT),
		.level(gain_select_input)
	);

	gsw_ramp u_ramp (
		.clk(MCLK),
		.rst_n(RSTN),
		.tick(s.tick),
		.target(s.set_two ? s.position_loop_gain_second :
			s.position_loop_gain_first),
		.ramp_time(s.position_gain_ramp_time),
		.gain(pos_gain)
	);

	// register access, time base, measurement and set decision
	always_comb begin
		logic [31:0] ctrl_word;
		logic [31:0] rd_value;
		logic [31:0] wr_word;
		logic [CMD_W:0] tq_delta;
		logic [CMD_W:0] sp_delta;
		logic [MAG_W-1:0] mag;
		logic [LVL_W:0] upper;
		logic [LVL_W:0] lower;
		logic judge;
		wr_word = '0;
		mag = '0;
		next_s = s;
		ctrl_word = '0;
		ctrl_word[CTRL_MODE_LSB +: 3] = s.speed_loop_switch_mode;
		ctrl_word[CTRL_OPSEL_BIT] = s.gain_input_op_select;
		ctrl_word[CTRL_SPDCTL_BIT] = s.speed_ctrl_mode;
		ctrl_word[CTRL_TLSEL_LSB +: 4] = s.torque_limit_select;

		// read mux; unmapped and reserved words read zero
		rd_value = '0;
		unique case (AVS_REQ.address)
			ADDR_CTRL: rd_value = ctrl_word;
			ADDR_DELAY: rd_value[TIME_W-1:0] = s.speed_switch_delay;
			ADDR_LEVEL: rd_value[LVL_W-1:0] = s.speed_switch_level;
			ADDR_HYST: rd_value[LVL_W-1:0] = s.speed_switch_hysteresis;
			ADDR_RAMP: rd_value[TIME_W-1:0] = s.position_gain_ramp_time;
			ADDR_GAIN_ONE: rd_value[GAIN_W-1:0] =
				s.position_loop_gain_first;
			ADDR_GAIN_TWO: rd_value[GAIN_W-1:0] =
				s.position_loop_gain_second;
			ADDR_STATUS: begin
				rd_value[STAT_SET_BIT] = s.set_two;
				rd_value[STAT_GAIN_SELECT_INPUT_BIT] = gain_select_input;
				rd_value[STAT_GAIN_LSB +: GAIN_W] = pos_gain;
			end
			default: rd_value = '0;
		endcase

		// one wait cycle, then the request is taken
		next_s.waitreq = 1'b1;
		if (AVS_REQ.read || AVS_REQ.write) begin
			if (s.waitreq) begin
				next_s.waitreq = 1'b0;
				next_s.rdata = rd_value;
			end else if (AVS_REQ.write) begin
				unique case (AVS_REQ.address)
					ADDR_CTRL: wr_word = merge(ctrl_word,
						AVS_REQ.writedata, AVS_REQ.byteenable);
					default: wr_word = merge(rd_value,
						AVS_REQ.writedata, AVS_REQ.byteenable);
				endcase
				unique case (AVS_REQ.address)
					ADDR_CTRL: begin
						next_s.speed_loop_switch_mode =
							wr_word[CTRL_MODE_LSB +: 3];
						next_s.gain_input_op_select =
							wr_word[CTRL_OPSEL_BIT];
						next_s.speed_ctrl_mode = wr_word[CTRL_SPDCTL_BIT];
						next_s.torque_limit_select =
							wr_word[CTRL_TLSEL_LSB +: 4];
					end
					ADDR_DELAY: next_s.speed_switch_delay =
						wr_word[TIME_W-1:0];
					ADDR_LEVEL: next_s.speed_switch_level =
						wr_word[LVL_W-1:0];
					ADDR_HYST: next_s.speed_switch_hysteresis =
						wr_word[LVL_W-1:0];
					ADDR_RAMP: next_s.position_gain_ramp_time =
						wr_word[TIME_W-1:0];
					ADDR_GAIN_ONE: next_s.position_loop_gain_first =
						wr_word[GAIN_W-1:0];
					ADDR_GAIN_TWO: next_s.position_loop_gain_second =
						wr_word[GAIN_W-1:0];
					default: ; // reserved and unmapped ignore writes
				endcase
			end
		end else begin
			wr_word = '0;
		end

		// 0.1 ms tick and 1 ms window end
		next_s.tick = 1'b0;
		next_s.win_end = 1'b0;
		next_s.prescale = s.prescale + PRE_W'(1);
		if (s.prescale == PRE_W'(TICK_CYCLES - 1)) begin
			next_s.prescale = '0;
			next_s.tick = 1'b1;
			next_s.win_cnt = s.win_cnt + 4'h1;
			if (s.win_cnt == 4'(WINDOW_TICKS - 1)) begin
				next_s.win_cnt = '0;
				next_s.win_end = 1'b1;
			end
		end

		// change over one window, magnitude only
		tq_delta = (CMD_W+1)'(TORQUE_CMD) - (CMD_W+1)'(s.torque_prev);
		sp_delta = (CMD_W+1)'(SPEED_CMD) - (CMD_W+1)'(s.speed_prev);
		if (s.win_end) begin
			next_s.torque_prev = TORQUE_CMD;
			next_s.speed_prev = SPEED_CMD;
			next_s.torque_mag = MAG_W'(magnitude(tq_delta));
			next_s.rate_mag = MAG_W'(magnitude(sp_delta)) *
				MAG_W'(RATE_SCALE);
		end

		// monitored quantity per mode
		unique case (s.speed_loop_switch_mode)
			MODE_TORQUE_CHG: mag = s.torque_mag;
			MODE_SPEED_CHG: mag = s.rate_mag;
			default: mag = MAG_W'(magnitude(
				(CMD_W+1)'(SPEED_CMD)));
		endcase

		// symmetric band around the level
		upper = {1'b0, s.speed_switch_level} +
			{1'b0, s.speed_switch_hysteresis};
		lower = (s.speed_switch_level > s.speed_switch_hysteresis) ?
			{1'b0, s.speed_switch_level - s.speed_switch_hysteresis} :
			'0;
		judge = s.speed_ctrl_mode &&
			(s.speed_loop_switch_mode == MODE_TORQUE_CHG ||
			s.speed_loop_switch_mode == MODE_SPEED_CHG ||
			s.speed_loop_switch_mode == MODE_SPEED);

		// gain set decision
		if (!s.gain_input_op_select) begin
			next_s.sel = SEL_ONE;
		end else if (judge) begin
			unique case (s.sel)
				SEL_ONE: begin
					if (mag > MAG_W'(upper)) begin
						next_s.sel = SEL_TWO;
					end
				end
				SEL_TWO: begin
					next_s.wait_cnt = '0;
					if (mag < MAG_W'(lower)) begin
						next_s.sel = (s.speed_switch_delay == '0) ?
							SEL_ONE : SEL_WAIT;
					end
				end
				SEL_WAIT: begin
					if (mag >= MAG_W'(lower)) begin
						next_s.sel = SEL_TWO;
					end else if (s.tick) begin
						next_s.wait_cnt = s.wait_cnt + TIME_W'(1);
						if (s.wait_cnt + TIME_W'(1) >=
							s.speed_switch_delay) begin
							next_s.sel = SEL_ONE;
						end
					end
				end
				default: next_s.sel = SEL_ONE;
			endcase
		end else begin
			unique case (s.speed_loop_switch_mode)
				MODE_FIX_ONE: next_s.sel = SEL_ONE;
				MODE_FIX_TWO: next_s.sel =
					(s.torque_limit_select == TLSEL_FORCE_A ||
					s.torque_limit_select == TLSEL_FORCE_B) ?
					SEL_ONE : SEL_TWO;
				MODE_INPUT: next_s.sel = gain_select_input ?
					SEL_TWO : SEL_ONE;
				default: next_s.sel = SEL_ONE;
			endcase
		end
		next_s.set_two = (next_s.sel != SEL_ONE);
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			s <= '0;
			s.waitreq <= 1'b1;
			s.speed_loop_switch_mode <= MODE_RESET;
			s.gain_input_op_select <= OPSEL_RESET;
			s.speed_ctrl_mode <= SPDCTL_RESET;
			s.torque_limit_select <= TLSEL_RESET;
			s.sel <= SEL_ONE;
		end else begin
			s <= next_s;
		end
	end

	assign AVS_READDATA = s.rdata;
	assign AVS_WAITREQUEST = s.waitreq;
	assign GAIN_SET_TWO = s.set_two;
	assign POSITION_LOOP_GAIN = pos_gain;
endmodule

// file: design/gsw_pkg.sv
/*
 * shared constants and types of the speed-loop gain-set switch:
 * timing figures, register offsets, field positions, reset values,
 * switching mode codes and the bus request carrier.
 * assumes a single 250 MHz control clock and an Avalon-MM host.
 */
package gsw_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_TIME_NS = 100000; // delay and ramp step, 0.1 ms
	localparam int WINDOW_TIME_NS = 1000000; // torque change window, 1 ms
	localparam int WINDOW_TICKS = WINDOW_TIME_NS / TICK_TIME_NS;
	localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
	// 1 ms change scaled to units of 10 r/min/s
	localparam int RATE_SCALE = 100;

	// widths
	localparam int CMD_W = 16;
	localparam int GAIN_W = 16;
	localparam int TIME_W = 14;
	localparam int LVL_W = 15;
	localparam int MAG_W = 24;
	localparam int PRE_W = 24;

	// register byte offsets
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_DELAY = 6'h04;
	localparam logic [5:0] ADDR_LEVEL = 6'h08;
	localparam logic [5:0] ADDR_HYST = 6'h0c;
	localparam logic [5:0] ADDR_RAMP = 6'h10;
	localparam logic [5:0] ADDR_GAIN_ONE = 6'h14;
	localparam logic [5:0] ADDR_GAIN_TWO = 6'h18;
	localparam logic [5:0] ADDR_STATUS = 6'h1c;

	// control and status register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_OPSEL_BIT = 4;
	localparam int CTRL_SPDCTL_BIT = 5;
	localparam int CTRL_TLSEL_LSB = 8;
	localparam int STAT_SET_BIT = 0;
	localparam int STAT_GAIN_SELECT_INPUT_BIT = 1;
	localparam int STAT_GAIN_LSB = 16;

	// reset values
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic OPSEL_RESET = 1'b1;
	localparam logic SPDCTL_RESET = 1'b1;
	localparam logic [3:0] TLSEL_RESET = 4'h0;

	// switching mode codes and the limit select codes that force set one
	localparam logic [2:0] MODE_FIX_ONE = 3'h0;
	localparam logic [2:0] MODE_FIX_TWO = 3'h1;
	localparam logic [2:0] MODE_INPUT = 3'h2;
	localparam logic [2:0] MODE_TORQUE_CHG = 3'h3;
	localparam logic [2:0] MODE_SPEED_CHG = 3'h4;
	localparam logic [2:0] MODE_SPEED = 3'h5;
	localparam logic [3:0] TLSEL_FORCE_A = 4'h3;
	localparam logic [3:0] TLSEL_FORCE_B = 4'h6;

	typedef enum logic [1:0] {SEL_ONE, SEL_TWO, SEL_WAIT} gsw_sel_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} gsw_avs_req_type;
endpackage

// file: design/gsw_sync.sv
/*
 * two-flop synchroniser for the external gain select pin.
 * assumes the pin is asynchronous to the control clock.
 */
`timescale 1ns/100ps
module gsw_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic level
);
	import gsw_pkg::*;

	typedef struct packed {
		logic meta;
		logic stable;
	} gsw_sync_state_type;

	gsw_sync_state_type s;
	gsw_sync_state_type next_s;

	// first stage feeds only the second
	always_comb begin
		next_s.meta = pin;
		next_s.stable = s.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.stable;
endmodule

// file: design/gsw_ramp.sv
/*
 * position loop gain follower: lowers at once, raises linearly over
 * the programmed ramp time in 0.1 ms ticks.
 * assumes a one-cycle tick pulse every 0.1 ms from the parent.
 */
`timescale 1ns/100ps
module gsw_ramp (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic [gsw_pkg::GAIN_W-1:0] target,
	input wire logic [gsw_pkg::TIME_W-1:0] ramp_time,
	output logic [gsw_pkg::GAIN_W-1:0] gain
);
	import gsw_pkg::*;

	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic [GAIN_W-1:0] goal;
		logic dividing;
		logic ramping;
		logic [4:0] bits_left;
		logic [GAIN_W-1:0] quo;
		logic [TIME_W:0] rem;
		logic [TIME_W:0] acc;
		logic [TIME_W-1:0] ticks_left;
	} gsw_ramp_state_type;

	gsw_ramp_state_type s;
	gsw_ramp_state_type next_s;

	// new goal, step division and per-tick ramp
	always_comb begin
		logic [TIME_W+1:0] shifted;
		logic [TIME_W+1:0] sum;
		next_s = s;
		shifted = {s.rem, s.quo[GAIN_W-1]};
		sum = {1'b0, s.acc} + {1'b0, s.rem};
		if (target != s.goal) begin
			next_s.goal = target;
			next_s.ramping = 1'b0;
			if (target <= s.gain || ramp_time == '0) begin
				next_s.gain = target;
				next_s.dividing = 1'b0;
			end else begin
				next_s.dividing = 1'b1;
				next_s.bits_left = 5'(GAIN_W);
				next_s.quo = target - s.gain;
				next_s.rem = '0;
				next_s.acc = '0;
				next_s.ticks_left = ramp_time;
			end
		end else if (s.dividing) begin
			next_s.quo = {s.quo[GAIN_W-2:0], 1'b0};
			next_s.rem = shifted[TIME_W:0];
			if (shifted >= {2'b00, ramp_time}) begin
				next_s.rem = (TIME_W+1)'(shifted - {2'b00, ramp_time});
				next_s.quo[0] = 1'b1;
			end
			next_s.bits_left = s.bits_left - 5'h01;
			if (s.bits_left == 5'h01) begin
				next_s.dividing = 1'b0;
				next_s.ramping = 1'b1;
			end
		end else if (s.ramping && tick) begin
			next_s.gain = s.gain + s.quo;
			next_s.acc = sum[TIME_W:0];
			if (sum >= {2'b00, ramp_time}) begin
				next_s.gain = s.gain + s.quo + GAIN_W'(1);
				next_s.acc = (TIME_W+1)'(sum - {2'b00, ramp_time});
			end
			next_s.ticks_left = s.ticks_left - TIME_W'(1);
			if (s.ticks_left == TIME_W'(1)) begin
				next_s.gain = s.goal;
				next_s.ramping = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign gain = s.gain;
endmodule

// file: verification/gsw_chk.sv
/*
 * port assertions for the gain-set switch, fed by a mirror of the
 * config words taken from accepted bus writes.
 * assumes full-word writes and the one-wait-cycle slave.
 */
`timescale 1ns/100ps
module gsw_chk #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire gsw_pkg::gsw_avs_req_type AVS_REQ,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic GAIN_SELECT_INPUT,
	input wire logic signed [gsw_pkg::CMD_W-1:0] TORQUE_CMD,
	input wire logic signed [gsw_pkg::CMD_W-1:0] SPEED_CMD,
	input wire logic GAIN_SET_TWO,
	input wire logic [gsw_pkg::GAIN_W-1:0] POSITION_LOOP_GAIN
);
	import gsw_pkg::*;
	logic [31:0] cfg [8];
	logic [2:0] age;
	logic [2:0] mode;
	logic signed [16:0] spd;
	logic [17:0] mag;
	logic wr_ok, on, tl_hit, s5, lo, hi;
	assign wr_ok = AVS_REQ.write && !AVS_WAITREQUEST;
	// mirror of written words; age counts edges since a control write
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cfg <= '{0: 32'h30, default: 32'h0};
			age <= 3'h0;
		end else begin
			if (wr_ok && !AVS_REQ.address[5])
				cfg[AVS_REQ.address[4:2]] <= AVS_REQ.writedata;
			if (wr_ok && AVS_REQ.address == ADDR_CTRL)
				age <= 3'h0;
			else if (!(&age))
				age <= age + 3'h1;
		end
	end
	// decoded settings and speed magnitude against the thresholds
	assign mode = cfg[0][2:0];
	assign on = age[2] && cfg[0][CTRL_OPSEL_BIT];
	assign tl_hit = cfg[0][11:8] == TLSEL_FORCE_A
		|| cfg[0][11:8] == TLSEL_FORCE_B;
	assign s5 = on && cfg[0][CTRL_SPDCTL_BIT] && mode == MODE_SPEED;
	assign spd = SPEED_CMD;
	assign mag = 18'(spd < 0 ? -spd : spd);
	assign hi = mag > 18'(cfg[2][14:0]) + 18'(cfg[3][14:0]);
	assign lo = mag + 18'(cfg[3][14:0]) < 18'(cfg[2][14:0]);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	AST_WAIT_ONE: assert property ((AVS_REQ.read || AVS_REQ.write)
		&& AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("waitrequest not low for one cycle");
	AST_UNMAPPED: assert property (AVS_REQ.read && !AVS_WAITREQUEST
		&& AVS_REQ.address[5] |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	AST_FIX_ONE: assert property (
		on && mode == MODE_FIX_ONE |-> !GAIN_SET_TWO)
		else $error("mode 0 left set one");
	AST_FIX_TWO: assert property (
		on && mode == MODE_FIX_TWO && !tl_hit |-> GAIN_SET_TWO)
		else $error("mode 1 left set two");
	AST_TL_FORCE: assert property (
		on && mode == MODE_FIX_TWO && tl_hit |-> !GAIN_SET_TWO)
		else $error("limit select did not force set one");
	AST_OPSEL_OFF: assert property (
		age[2] && !cfg[0][CTRL_OPSEL_BIT] |-> !GAIN_SET_TWO)
		else $error("set two with op select off");
	AST_PIN: assert property (
		on && mode == MODE_INPUT
		|-> GAIN_SET_TWO == $past(GAIN_SELECT_INPUT, 3))
		else $error("set does not follow gain select");
	AST_SPD_UP: assert property (s5 && hi |=> GAIN_SET_TWO)
		else $error("no set two above level");
	AST_SPD_DOWN: assert property (
		s5 && lo && cfg[1][13:0] == 14'h0 |=> !GAIN_SET_TWO)
		else $error("no return with zero delay");
	AST_SPD_HOLD: assert property (
		s5 && !lo && !hi |=> $stable(GAIN_SET_TWO))
		else $error("set changed inside hysteresis band");
	AST_SPD_DELAY: assert property (
		s5 && GAIN_SET_TWO && lo && !$past(lo)
		&& cfg[1][13:0] >= 14'h2 |=> GAIN_SET_TWO [*8])
		else $error("return came before delay");
	AST_SPDCTL_OFF: assert property (
		on && !cfg[0][CTRL_SPDCTL_BIT] && mode >= MODE_TORQUE_CHG
		&& mode <= MODE_SPEED |-> !GAIN_SET_TWO)
		else $error("level judged outside speed control");
endmodule

bind gsw_switch gsw_chk #(.TICK_CYCLES(TICK_CYCLES)) gsw_chk_i (
	.MCLK(MCLK), .RSTN(RSTN), .AVS_REQ(AVS_REQ),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.GAIN_SELECT_INPUT(GAIN_SELECT_INPUT), .TORQUE_CMD(TORQUE_CMD),
	.SPEED_CMD(SPEED_CMD), .GAIN_SET_TWO(GAIN_SET_TWO),
	.POSITION_LOOP_GAIN(POSITION_LOOP_GAIN)
);

// file: verification/gsw_host.sv
/*
 * host controller model driving the gain select pin.
 * assumes the bench names the wanted set just after a clock edge.
 */
`timescale 1ns/100ps
module gsw_host (
	input wire logic clk,
	input wire logic want_two,
	input wire logic slow,
	output logic pin
);
	logic held;
	initial pin = 1'b0;
	initial held = 1'b0;
	// pin follows the wanted set, one cycle later when slow
	always @(posedge clk) begin
		held <= want_two;
		pin <= slow ? held : want_two;
	end
endmodule

// file: verification/gsw_switch_tb.sv
/*
 * self-checking bench for the gain-set switch: bus master tasks,
 * command stimulus and one task per scenario.
 * assumes the package constants and a 0.1 ms tick of TICK cycles.
 */
`timescale 1ns/100ps
module gsw_switch_tb;
	import gsw_pkg::*;
	localparam int TICK = 10;
	logic mclk = 1'b0;
	logic rstn = 1'b1;
	gsw_avs_req_type req = '0;
	logic [31:0] rdata, q;
	logic wait_req, pin, set_two;
	logic want_two = 1'b0;
	logic slow = 1'b0;
	logic signed [CMD_W-1:0] torque = '0;
	logic signed [CMD_W-1:0] speed = '0;
	logic [GAIN_W-1:0] gain;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	always #2 mclk = ~mclk;
	gsw_host gsw_host_i (.clk(mclk), .want_two(want_two), .slow(slow),
		.pin(pin));
	gsw_switch #(.TICK_CYCLES(TICK)) gsw_switch_i (.MCLK(mclk),
		.RSTN(rstn), .AVS_REQ(req), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .GAIN_SELECT_INPUT(pin),
		.TORQUE_CMD(torque), .SPEED_CMD(speed), .GAIN_SET_TWO(set_two),
		.POSITION_LOOP_GAIN(gain));
	// compare helpers count every comparison
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: word %h not %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: flag %b not %b", $time, g, e);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one bus access: hold until waitrequest is seen low, then release
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		req.read <= !w;
		req.write <= w;
		req.address <= a;
		req.byteenable <= 4'hf;
		req.writedata <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		chk_bit(wait_req, 1'b0);
		q = rdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge mclk);
	endtask
	// wait a bounded time for the active set to reach v
	task automatic wait_set(input logic v, input int lim);
		int n;
		n = 0;
		while (set_two !== v && n < lim) begin
			@(posedge mclk);
			n++;
		end
		chk_bit(set_two, v);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 9; i++) begin
			bus(1'b0, 6'(4 * i), 32'h0);
			chk_word(q, i == 0 ? 32'h30 : 32'h0);
		end
		bus(1'b1, ADDR_LEVEL, 32'hffff_ffff);
		bus(1'b0, ADDR_LEVEL, 32'h0);
		chk_word(q, 32'h7fff);
		bus(1'b1, ADDR_STATUS, 32'hffff_ffff);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk_word(q, 32'h0);
		bus(1'b1, 6'h24, 32'h0);
		bus(1'b0, 6'h24, 32'h0);
		chk_word(q, 32'h0);
		bus(1'b1, ADDR_LEVEL, 32'h0);
		$display("register test done");
	endtask
	task automatic t_fixed();
		logic [31:0] cv [6] = '{32'h31, 32'h331, 32'h631, 32'h21,
			32'h30, 32'h31};
		logic ev [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		bus(1'b1, ADDR_GAIN_ONE, 32'h64);
		bus(1'b1, ADDR_GAIN_TWO, 32'h28);
		bus(1'b1, ADDR_RAMP, 32'h3);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, ADDR_CTRL, cv[i]);
			repeat (4) @(posedge mclk);
			chk_bit(set_two, ev[i]);
			if (ev[i])
				chk_word(32'(gain), 32'h28);
			else
				chk_bit(1'(gain >= 16'h28 && gain <= 16'h64), 1'b1);
		end
		chk_word(32'(gain), 32'h28);
		bus(1'b1, ADDR_CTRL, 32'h30);
		repeat (6) @(posedge mclk);
		chk_bit(1'(gain < 16'h64), 1'b1);
		repeat (17 + 4 * TICK) @(posedge mclk);
		chk_word(32'(gain), 32'h64);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk_word(q, 32'h0064_0000);
		$display("fixed set test done");
	endtask
	task automatic t_pin();
		bus(1'b1, ADDR_DELAY, 32'h5);
		bus(1'b1, ADDR_CTRL, 32'h32);
		want_two <= 1'b1;
		wait_set(1'b1, 8);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk_word(q, 32'h0028_0003);
		slow <= 1'b1;
		want_two <= 1'b0;
		wait_set(1'b0, 8);
		slow <= 1'b0;
		$display("pin test done");
	endtask
	task automatic t_speed();
		bus(1'b1, ADDR_DELAY, 32'h0);
		bus(1'b1, ADDR_LEVEL, 32'h3e8);
		bus(1'b1, ADDR_HYST, 32'h64);
		bus(1'b1, ADDR_CTRL, 32'h35);
		speed <= -16'sd1200;
		wait_set(1'b1, 3);
		speed <= 16'sd950;
		repeat (10) @(posedge mclk);
		chk_bit(set_two, 1'b1);
		speed <= 16'sd800;
		wait_set(1'b0, 3);
		bus(1'b1, ADDR_DELAY, 32'h5);
		speed <= 16'sd1200;
		wait_set(1'b1, 3);
		speed <= -16'sd800;
		repeat (20) @(posedge mclk);
		chk_bit(set_two, 1'b1);
		wait_set(1'b0, 80);
		speed <= 16'sd1200;
		bus(1'b1, ADDR_CTRL, 32'h15);
		repeat (5) @(posedge mclk);
		chk_bit(set_two, 1'b0);
		bus(1'b1, ADDR_DELAY, 32'h0);
		bus(1'b1, ADDR_HYST, 32'h0);
		speed <= 16'sd0;
		$display("speed test done");
	endtask
	// change modes: a step below the level, then one above it
	task automatic t_chg(input logic [31:0] c, input logic [31:0] l,
		input logic signed [CMD_W-1:0] a, input logic signed [CMD_W-1:0] b);
		bus(1'b1, ADDR_LEVEL, l);
		bus(1'b1, ADDR_CTRL, c);
		if (c[0])
			torque <= a;
		else
			speed <= a;
		repeat (250) @(posedge mclk);
		chk_bit(set_two, 1'b0);
		if (c[0])
			torque <= b;
		else
			speed <= b;
		wait_set(1'b1, 250);
		wait_set(1'b0, 250);
		$display("change test done");
	endtask
	// main sequence
	initial begin
		rstn <= 1'b0;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_fixed();
		t_pin();
		t_speed();
		t_chg(32'h33, 32'hc8, 16'sd150, 16'sd450);
		t_chg(32'h34, 32'h1f4, 16'sd4, 16'sd10);
		give_verdict();
	end
	// cut a hung run short
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
endmodule
